/* File: shared/fpm_map.svh */
// offsets, field positions, reset values and timing figures of the mode menu
// assumes a byte-addressed register port with 32-bit aligned words
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH

`define FPM_ADDR_W          8
`define FPM_OFS_STATUS      8'h00
`define FPM_OFS_IRQ_STAT    8'h04
`define FPM_OFS_IRQ_CLR     8'h08
`define FPM_OFS_IRQ_EN      8'h0C
`define FPM_OFS_ITEM_LIMIT  8'h10

`define FPM_ST_MODE_LSB     0
`define FPM_ST_ITEM_LSB     4
`define FPM_ST_ARMED_BIT    8
`define FPM_ST_READY_BIT    9

`define FPM_EV_EXEC         0
`define FPM_EV_CANCEL       1
`define FPM_EV_TIMEOUT      2
`define FPM_EV_FAULT        3
`define FPM_EV_OVERCUR      4
`define FPM_EV_W            5

`define FPM_ITEM_W          4
`define FPM_ITEM_LIMIT_RST  4'hF
`define FPM_CURRENT_ITEMS   4'h1
`define FPM_TRIP_W          4
`define FPM_MODE_N          7

`define FPM_CLK_HZ          25000000
`define FPM_TIMEOUT_S       60
`define FPM_BLINK_MS        250
`define FPM_DIM_SHIFT       4

`endif

/* File: shared/fpm_pkg.sv */
// types of the front-panel mode menu
// assumes fpm_map.svh is on the include path
`include "fpm_map.svh"

package fpm_pkg;

    typedef enum logic [2:0] {
        MODE_RUN,
        MODE_INSTALL,
        MODE_CHECK,
        MODE_TEMP_SET,
        MODE_TEMP,
        MODE_CURRENT,
        MODE_FAULT
    } fpm_mode_t;

    typedef struct packed {
        fpm_mode_t                  mode;
        logic [`FPM_ITEM_W-1:0]     item;
        logic                       armed;
        logic [5:0]                 keyPrev;
        logic [`FPM_DIM_SHIFT-1:0]  pwm;
        logic                       blinkPhase;
        logic                       faultPrev;
        logic                       ocPrev;
        logic                       execPulse;
        fpm_mode_t                  execMode;
        logic [`FPM_ITEM_W-1:0]     execItem;
        logic [`FPM_EV_W-1:0]       irqStat;
        logic [`FPM_EV_W-1:0]       irqEn;
        logic [`FPM_ITEM_W-1:0]     itemLimit;
        logic [31:0]                rdData;
        logic                       irq;
        logic [`FPM_MODE_N-1:0]     modeLamp;
        logic                       displayBlink;
        logic                       linkActivityLamp;
        logic                       errorLamp;
        logic                       intOcLamp;
        logic                       extOcLamp;
        logic [`FPM_TRIP_W-1:0]     tripLamp;
        logic                       ioLinkLamp;
        logic                       ioErrorLamp;
        logic                       protReady;
    } fpm_state_t;

endpackage : fpm_pkg

/* File: rtl/fpm_pulse_div.sv */
// enable divider: one-cycle tick every 'limit' clocks, restarted by clr
// assumes limit is static or changes only while clr is high
module fpm_pulse_div #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             clr,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  tick
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             tick;
    } fpm_div_t;

    fpm_div_t st_r;
    fpm_div_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (clr) begin
            st_nxt.count = '0;
        end else if (st_r.count >= limit - WIDTH'(1)) begin
            st_nxt.count = '0;
            st_nxt.tick  = 1'b1;
        end else begin
            st_nxt.count = st_r.count + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule : fpm_pulse_div

/* File: rtl/fpm_menu.sv */
// front-panel mode menu, key handling and indicator lamps of the central unit
// assumes keys are debounced levels synchronous to clk_sys, high while pressed
`include "fpm_map.svh"

module fpm_menu #(
    parameter int TIMEOUT_CYCLES = `FPM_TIMEOUT_S * `FPM_CLK_HZ,
    parameter int BLINK_CYCLES   = `FPM_BLINK_MS * (`FPM_CLK_HZ / 1000)
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic [`FPM_ADDR_W-1:0]    regAddr,
    input  wire logic [31:0]               regWrData,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [31:0]               regRdData,
    output logic                           irq,
    input  wire logic                      keyUp,
    input  wire logic                      keyDown,
    input  wire logic                      keyLeft,
    input  wire logic                      keyRight,
    input  wire logic                      keySet,
    input  wire logic                      keyEnter,
    input  wire logic                      sysConfigured,
    input  wire logic                      powerGood,
    input  wire logic                      linkMsg,
    input  wire logic                      selfFault,
    input  wire logic                      localOc,
    input  wire logic                      remoteOc,
    input  wire logic [`FPM_TRIP_W-1:0]    tripStage,
    input  wire logic                      ioLink,
    input  wire logic                      ioFault,
    output logic      [`FPM_MODE_N-1:0]    modeLamp,
    output logic                           displayBlink,
    output logic                           linkActivityLamp,
    output logic                           errorLamp,
    output logic                           intOcLamp,
    output logic                           extOcLamp,
    output logic      [`FPM_TRIP_W-1:0]    tripLamp,
    output logic                           ioLinkLamp,
    output logic                           ioErrorLamp,
    output logic                           protReady,
    output logic                           execPulse,
    output fpm_pkg::fpm_mode_t             execMode,
    output logic      [`FPM_ITEM_W-1:0]    execItem
);
    localparam int TMO_W = 32;
    localparam int BLK_W = 24;

    fpm_pkg::fpm_state_t st_r;
    fpm_pkg::fpm_state_t st_nxt;

    logic [5:0] keys;
    logic [5:0] press;
    logic       anyPress;
    logic       tmoTick;
    logic       blinkTick;
    logic       pressUp;
    logic       pressDown;
    logic       pressLeft;
    logic       pressRight;
    logic       pressSet;
    logic       pressEnter;

    assign keys       = {keyEnter, keySet, keyRight, keyLeft, keyDown, keyUp};
    assign press      = keys & ~st_r.keyPrev;
    assign anyPress   = |press;
    assign pressUp    = press[0];
    assign pressDown  = press[1];
    assign pressLeft  = press[2];
    assign pressRight = press[3];
    assign pressSet   = press[4];
    assign pressEnter = press[5];

    // inactivity timer, restarted by every key press
    fpm_pulse_div #(
        .WIDTH (TMO_W)
    ) u_timeout (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clr     (anyPress),
        .limit   (TMO_W'(TIMEOUT_CYCLES)),
        .tick    (tmoTick)
    );

    // half period of every blinking lamp
    fpm_pulse_div #(
        .WIDTH (BLK_W)
    ) u_blink (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clr     (1'b0),
        .limit   (BLK_W'(BLINK_CYCLES)),
        .tick    (blinkTick)
    );

    function automatic logic [`FPM_ITEM_W-1:0] item_max(fpm_pkg::fpm_mode_t m,
                                                       logic [`FPM_ITEM_W-1:0] lim);
        logic [`FPM_ITEM_W-1:0] r;
        r = '0;
        case (m)
            fpm_pkg::MODE_CHECK:   r = lim;
            fpm_pkg::MODE_CURRENT: r = `FPM_CURRENT_ITEMS;
            default:               r = '0;
        endcase
        return r;
    endfunction : item_max

    always_comb begin
        logic [`FPM_EV_W-1:0]   ev;
        logic [`FPM_EV_W-1:0]   clrMask;
        logic [`FPM_ITEM_W-1:0] iMax;
        ev      = '0;
        clrMask = '0;
        iMax    = item_max(st_r.mode, st_r.itemLimit);
        st_nxt  = st_r;

        st_nxt.keyPrev   = keys;
        st_nxt.execPulse = 1'b0;
        st_nxt.pwm       = st_r.pwm + `FPM_DIM_SHIFT'(1);
        if (blinkTick) begin
            st_nxt.blinkPhase = ~st_r.blinkPhase;
        end

        // menu: timeout first, then set/enter, then navigation
        if (tmoTick) begin
            st_nxt.mode = fpm_pkg::MODE_RUN;
            st_nxt.item = '0;
            ev[`FPM_EV_TIMEOUT] = 1'b1;
            if (st_r.armed) begin
                st_nxt.armed = 1'b0;
                ev[`FPM_EV_CANCEL] = 1'b1;
            end
        end else if (pressSet) begin
            st_nxt.armed = ~st_r.armed;
            ev[`FPM_EV_CANCEL] = st_r.armed;
        end else if (pressEnter && st_r.armed) begin
            st_nxt.armed     = 1'b0;
            st_nxt.execPulse = 1'b1;
            st_nxt.execMode  = st_r.mode;
            st_nxt.execItem  = st_r.item;
            ev[`FPM_EV_EXEC] = 1'b1;
        end else if (!st_r.armed) begin
            // navigation frozen while armed so the armed target cannot drift
            if (pressUp) begin
                st_nxt.item = '0;
                st_nxt.mode = (st_r.mode == fpm_pkg::MODE_RUN) ? fpm_pkg::MODE_FAULT
                            : fpm_pkg::fpm_mode_t'(st_r.mode - 3'h1);
            end else if (pressDown) begin
                st_nxt.item = '0;
                st_nxt.mode = (st_r.mode == fpm_pkg::MODE_FAULT) ? fpm_pkg::MODE_RUN
                            : fpm_pkg::fpm_mode_t'(st_r.mode + 3'h1);
            end else if (pressRight) begin
                st_nxt.item = (st_r.item >= iMax) ? '0
                            : st_r.item + `FPM_ITEM_W'(1);
            end else if (pressLeft) begin
                st_nxt.item = (st_r.item == '0) ? iMax
                            : st_r.item - `FPM_ITEM_W'(1);
            end
        end

        // lamps, registered so every output comes from a flop
        st_nxt.modeLamp = '0;
        st_nxt.modeLamp[st_nxt.mode] = 1'b1;
        st_nxt.displayBlink = st_nxt.armed & st_nxt.blinkPhase;
        st_nxt.linkActivityLamp = (st_nxt.mode == fpm_pkg::MODE_INSTALL)
                                & linkMsg & st_nxt.blinkPhase;
        // faint pattern: short duty slice during one blink phase only
        st_nxt.errorLamp = selfFault
                         | (st_nxt.blinkPhase & (st_nxt.pwm == '0));
        st_nxt.intOcLamp   = localOc;
        st_nxt.extOcLamp   = remoteOc;
        st_nxt.tripLamp    = tripStage;
        st_nxt.ioLinkLamp  = ioLink;
        st_nxt.ioErrorLamp = ioFault;
        // taken from supply and configuration alone, never from menu state
        st_nxt.protReady   = sysConfigured & powerGood;

        st_nxt.faultPrev = selfFault;
        st_nxt.ocPrev    = localOc | remoteOc;
        ev[`FPM_EV_FAULT]   = selfFault & ~st_r.faultPrev;
        ev[`FPM_EV_OVERCUR] = (localOc | remoteOc) & ~st_r.ocPrev;

        // register port writes
        if (regWr) begin
            case (regAddr)
                `FPM_OFS_IRQ_CLR:    clrMask = regWrData[`FPM_EV_W-1:0];
                `FPM_OFS_IRQ_EN:     st_nxt.irqEn = regWrData[`FPM_EV_W-1:0];
                `FPM_OFS_ITEM_LIMIT: st_nxt.itemLimit = regWrData[`FPM_ITEM_W-1:0];
                default:             clrMask = '0;
            endcase
        end
        // a new event wins over a clear in the same cycle
        st_nxt.irqStat = (st_r.irqStat & ~clrMask) | ev;
        st_nxt.irq     = |(st_nxt.irqStat & st_nxt.irqEn);

        // read data stand only in the cycle after the strobe
        st_nxt.rdData = '0;
        if (regRd) begin
            case (regAddr)
                `FPM_OFS_STATUS: begin
                    st_nxt.rdData[`FPM_ST_MODE_LSB +: 3] = st_r.mode;
                    st_nxt.rdData[`FPM_ST_ITEM_LSB +: `FPM_ITEM_W] = st_r.item;
                    st_nxt.rdData[`FPM_ST_ARMED_BIT] = st_r.armed;
                    st_nxt.rdData[`FPM_ST_READY_BIT] = st_r.protReady;
                end
                `FPM_OFS_IRQ_STAT:   st_nxt.rdData[`FPM_EV_W-1:0] = st_r.irqStat;
                `FPM_OFS_IRQ_EN:     st_nxt.rdData[`FPM_EV_W-1:0] = st_r.irqEn;
                `FPM_OFS_ITEM_LIMIT: st_nxt.rdData[`FPM_ITEM_W-1:0] = st_r.itemLimit;
                default:             st_nxt.rdData = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r           <= '0;
            st_r.mode      <= fpm_pkg::MODE_RUN;
            st_r.execMode  <= fpm_pkg::MODE_RUN;
            st_r.modeLamp  <= `FPM_MODE_N'(1);
            st_r.itemLimit <= `FPM_ITEM_LIMIT_RST;
            st_r.keyPrev   <= 6'h3F;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData        = st_r.rdData;
    assign irq              = st_r.irq;
    assign modeLamp         = st_r.modeLamp;
    assign displayBlink     = st_r.displayBlink;
    assign linkActivityLamp = st_r.linkActivityLamp;
    assign errorLamp        = st_r.errorLamp;
    assign intOcLamp        = st_r.intOcLamp;
    assign extOcLamp        = st_r.extOcLamp;
    assign tripLamp         = st_r.tripLamp;
    assign ioLinkLamp       = st_r.ioLinkLamp;
    assign ioErrorLamp      = st_r.ioErrorLamp;
    assign protReady        = st_r.protReady;
    assign execPulse        = st_r.execPulse;
    assign execMode         = st_r.execMode;
    assign execItem         = st_r.execItem;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_armed_set;
        !st_r.armed && pressSet && !tmoTick;
    endsequence
    sequence s_armed_enter;
        st_r.armed && pressEnter && !pressSet && !tmoTick;
    endsequence

    a_mode_lamp_onehot: assert property ($onehot(modeLamp))
        else $error("mode lamps not one-hot");
    a_down_steps_fwd: assert property (
        !st_r.armed && pressDown && !pressSet && !tmoTick && !pressEnter
        && st_r.mode == fpm_pkg::MODE_RUN |=> st_r.mode == fpm_pkg::MODE_INSTALL)
        else $error("down key did not step forward");
    a_set_arms_blink: assert property (
        s_armed_set |=> st_r.armed ##0 (displayBlink == st_r.blinkPhase))
        else $error("set did not arm or blink wrong");
    a_enter_executes: assert property (
        s_armed_enter |=> execPulse && !st_r.armed ##1 !execPulse)
        else $error("enter did not execute once");
    a_set_cancels: assert property (
        st_r.armed && pressSet && !tmoTick |=> !st_r.armed && !execPulse
        ##0 !displayBlink)
        else $error("second set did not cancel");
    a_right_item: assert property (
        !st_r.armed && pressRight && !pressUp && !pressDown && !pressSet
        && !pressEnter && !tmoTick && st_r.mode == fpm_pkg::MODE_CURRENT
        && st_r.item == '0 |=> st_r.item == `FPM_ITEM_W'(1))
        else $error("right key did not step item");
    a_timeout_run: assert property (
        tmoTick |=> st_r.mode == fpm_pkg::MODE_RUN && modeLamp[0])
        else $error("timeout did not return to normal");
    // first edge after release still shows reset values, so start one edge later
    a_prot_ready: assert property (
        $past(rst_n) |-> protReady == $past(sysConfigured & powerGood))
        else $error("readiness not from supply and configuration");
    a_link_lamp: assert property (
        linkActivityLamp |-> $past(linkMsg) && st_r.mode == fpm_pkg::MODE_INSTALL)
        else $error("link lamp outside install activity");
    a_error_steady: assert property (
        selfFault [*2] |-> errorLamp)
        else $error("error lamp not steady on fault");
    a_oc_lamps: assert property (
        $past(rst_n) |-> intOcLamp == $past(localOc) && extOcLamp == $past(remoteOc))
        else $error("overcurrent lamps wrong");
    a_trip_lamps: assert property (
        $past(rst_n) |-> tripLamp == $past(tripStage))
        else $error("trip lamps wrong");
    a_io_lamps: assert property (
        $past(rst_n) |-> ioLinkLamp == $past(ioLink) && ioErrorLamp == $past(ioFault))
        else $error("unit lamps wrong");
    a_timeout_cancel: assert property (
        tmoTick && st_r.armed |=> !st_r.armed && !execPulse && st_r.irqStat[`FPM_EV_CANCEL])
        else $error("timeout left function armed");

endmodule : fpm_menu

/* File: testbench/fpm_keypad.sv */
// operator keypad model: presses one key on request, two cycles down, two up
// assumes keyGo is a one-cycle request issued just after a rising edge
module fpm_keypad (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [2:0] keySel,
    input  wire logic       keyGo,
    output logic      [5:0] keys,
    output logic            busy
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [2:0] step_r;
    logic [2:0] sel_r;

    // low tail keeps the key released a while before the next press
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            step_r <= 3'h0;
            sel_r  <= 3'h0;
        end else if (keyGo) begin
            step_r <= 3'h4;
            sel_r  <= keySel;
        end else if (step_r != 3'h0) begin
            step_r <= step_r - 3'h1;
        end
    end

    assign keys = (step_r > 3'h2) ? (6'h01 << sel_r) : 6'h00;
    assign busy = keyGo || (step_r != 3'h0);
endmodule : fpm_keypad

/* File: testbench/tb.sv */
// self-checking bench of the mode menu: register port tasks, keypad model
// assumes short timeout and blink parameters so the run stays brief
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TO = 200;
    localparam int UP = 0;
    localparam int DN = 1;
    localparam int LF = 2;
    localparam int RT = 3;
    localparam int ST = 4;
    localparam int EN = 5;

    logic               clk_sys = 1'b0;
    logic               rst_n = 1'b0;
    logic [7:0]         regAddr = 8'h00;
    logic [31:0]        regWrData = 32'h0000_0000;
    logic               regWr = 1'b0;
    logic               regRd = 1'b0;
    logic [2:0]         keySel = 3'h0;
    logic               keyGo = 1'b0;
    logic               linkMsg = 1'b0;
    logic               selfFault = 1'b0;
    logic [7:0]         pins = 8'h00;
    logic [31:0]        regRdData;
    logic [5:0]         keys;
    logic [6:0]         modeLamp;
    logic [3:0]         tripLamp;
    logic [3:0]         execItem;
    fpm_pkg::fpm_mode_t execMode;
    logic               irq, kpBusy, displayBlink, linkActivityLamp, errorLamp;
    logic               intOcLamp, extOcLamp, ioLinkLamp, ioErrorLamp, protReady;
    logic               execPulse, seenBlink, seenLink, seenErrHi, seenErrLo;
    logic               powerGood = 1'b1;
    logic               sysConfigured = 1'b1;
    int                 errors = 0;
    int                 tests_run = 0;
    int                 execCnt = 0;
    int                 ks[7] = '{RT, RT, RT, LF, RT, RT, LF};
    int                 ex[7] = '{1, 2, 0, 2, 1, 0, 1};

    fpm_keypad kp (.clk_sys(clk_sys), .rst_n(rst_n), .keySel(keySel), .keyGo(keyGo),
        .keys(keys), .busy(kpBusy));

    fpm_menu #(.TIMEOUT_CYCLES(TO), .BLINK_CYCLES(8)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq),
        .keyUp(keys[0]), .keyDown(keys[1]), .keyLeft(keys[2]), .keyRight(keys[3]),
        .keySet(keys[4]), .keyEnter(keys[5]), .sysConfigured(sysConfigured),
        .powerGood(powerGood), .linkMsg(linkMsg), .selfFault(selfFault),
        .localOc(pins[0]), .remoteOc(pins[1]), .tripStage(pins[7:4]),
        .ioLink(pins[2]), .ioFault(pins[3]), .modeLamp(modeLamp),
        .displayBlink(displayBlink), .linkActivityLamp(linkActivityLamp),
        .errorLamp(errorLamp), .intOcLamp(intOcLamp), .extOcLamp(extOcLamp),
        .tripLamp(tripLamp), .ioLinkLamp(ioLinkLamp), .ioErrorLamp(ioErrorLamp),
        .protReady(protReady), .execPulse(execPulse), .execMode(execMode),
        .execItem(execItem));

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (execPulse === 1'b1) execCnt++;
    end

    task automatic close_out();
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk_bit

    function automatic logic [31:0] st(input logic [2:0] m, input logic [3:0] it,
                                       input logic ar);
        return {22'h0, 1'b1, ar, it, 1'b0, m};
    endfunction : st

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWr <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRd <= 1'b0;
        #1;
        chk_reg(regRdData, exp);
    endtask : rd

    task automatic press(input int k);
        int n;
        @(posedge clk_sys);
        keySel <= 3'(k);
        keyGo <= 1'b1;
        @(posedge clk_sys);
        keyGo <= 1'b0;
        #1;
        for (n = 0; n < 20 && kpBusy !== 1'b0; n++) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : press

    task automatic watch(input int n);
        seenBlink = 1'b0;
        seenLink = 1'b0;
        seenErrHi = 1'b0;
        seenErrLo = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            if (displayBlink === 1'b1) seenBlink = 1'b1;
            if (linkActivityLamp === 1'b1) seenLink = 1'b1;
            if (errorLamp === 1'b1) seenErrHi = 1'b1;
            if (errorLamp !== 1'b1) seenErrLo = 1'b1;
        end
    endtask : watch

    // inputs pass to their lamps one cycle later
    task automatic lamps(input logic [7:0] p);
        @(posedge clk_sys);
        pins <= p;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_reg({24'h0, tripLamp, ioErrorLamp, ioLinkLamp, extOcLamp, intOcLamp},
                {24'h0, p});
    endtask : lamps

    initial begin
        #(40 * 20000);
        errors++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(8'h00, st(0, 0, 0));
        chk_reg({25'h0, modeLamp}, 32'h0000_0001);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h10, 32'h0000_000F);
        rd(8'h08, 32'h0000_0000);
        rd(8'h14, 32'h0000_0000);
        wr(8'h00, 32'hFFFF_FFFF);
        rd(8'h00, st(0, 0, 0));
        for (int i = 1; i <= 7; i++) begin
            press(DN);
            rd(8'h00, st(3'(i % 7), 0, 0));
            chk_reg({25'h0, modeLamp}, 32'h0000_0001 << (i % 7));
        end
        press(UP);
        rd(8'h00, st(6, 0, 0));
        repeat (3) press(DN);
        wr(8'h10, 32'h0000_0002);
        for (int i = 0; i < 7; i++) begin
            if (i == 4) begin
                repeat (3) press(DN);
                rd(8'h00, st(5, 0, 0));
            end
            press(ks[i]);
            rd(8'h00, st((i < 4) ? 3'h2 : 3'h5, 4'(ex[i]), 0));
        end
        wr(8'h0C, 32'h0000_0001);
        press(ST);
        rd(8'h00, st(5, 1, 1));
        watch(40);
        chk_bit(seenBlink, 1'b1);
        press(DN);
        rd(8'h00, st(5, 1, 1));
        press(EN);
        rd(8'h00, st(5, 1, 0));
        chk_reg(32'(execCnt), 32'h0000_0001);
        chk_reg({25'h0, execMode, execItem}, 32'h0000_0051);
        chk_bit(irq, 1'b1);
        rd(8'h04, 32'h0000_0001);
        wr(8'h08, 32'h0000_0001);
        rd(8'h04, 32'h0000_0000);
        chk_bit(irq, 1'b0);
        watch(40);
        chk_bit(seenBlink, 1'b0);
        press(ST);
        press(ST);
        rd(8'h00, st(5, 1, 0));
        watch(40);
        chk_bit(seenBlink, 1'b0);
        chk_reg(32'(execCnt), 32'h0000_0001);
        rd(8'h04, 32'h0000_0002);
        wr(8'h08, 32'h0000_001F);
        press(ST);
        repeat (150) @(posedge clk_sys);
        press(LF);
        repeat (150) @(posedge clk_sys);
        rd(8'h00, st(5, 1, 1));
        repeat (60) @(posedge clk_sys);
        rd(8'h00, st(0, 0, 0));
        rd(8'h04, 32'h0000_0006);
        chk_reg(32'(execCnt), 32'h0000_0001);
        press(DN);
        @(posedge clk_sys);
        linkMsg <= 1'b1;
        watch(40);
        chk_bit(seenLink, 1'b1);
        press(UP);
        watch(40);
        chk_bit(seenLink, 1'b0);
        watch(600);
        chk_bit(seenErrHi, 1'b1);
        chk_bit(seenErrLo, 1'b1);
        press(LF);
        wr(8'h08, 32'h0000_001F);
        selfFault <= 1'b1;
        watch(20);
        chk_bit(seenErrLo, 1'b0);
        lamps(8'hA5);
        lamps(8'h5A);
        rd(8'h04, 32'h0000_0018);
        chk_bit(protReady, 1'b1);
        @(posedge clk_sys);
        powerGood <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_bit(protReady, 1'b0);
        @(posedge clk_sys);
        powerGood <= 1'b1;
        sysConfigured <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_bit(protReady, 1'b0);
        @(posedge clk_sys);
        sysConfigured <= 1'b1;
        press(DN);
        #1;
        chk_bit(protReady, 1'b1);
        close_out();
    end
endmodule : tb
